// File: core/ptm_defines.svh
// offsets, field positions, reset values and widths of the pwm timer/mirror bank
// assumes it is included by bare name from the core files
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH

// bus geometry
`define PTM_ADDR_W 8
`define PTM_DATA_W 8

// shared mirror bytes
`define PTM_OFS_EN_MIRROR 8'h00
`define PTM_OFS_ARM_MIRROR 8'h01
`define PTM_OFS_LVL_MIRROR 8'h02

// per-generator pages, selected by the upper address nibble
`define PTM_PAGE_GEN5 4'h1
`define PTM_PAGE_GEN6 4'h2
`define PTM_PAGE_GEN11 4'h3

// register within a generator page, lower address nibble
`define PTM_SUB_TMR_LOW 4'h0
`define PTM_SUB_TMR_HIGH 4'h1
`define PTM_SUB_CTRL 4'h2
`define PTM_SUB_LDCTRL 4'h3

// field positions
`define PTM_CTRL_ON_BIT 7
`define PTM_CTRL_LEVEL_BIT 5
`define PTM_LDCTRL_ARM_BIT 7
`define PTM_MIRROR_W 3

// reset values
`define PTM_TMR_RST 8'h00
`define PTM_MIRROR_RST 3'h0
`define PTM_RDATA_RST 8'h00

`endif

// File: core/ptm_pkg.sv
// types shared by the pwm timer/mirror bank
// assumes nothing beyond a single compile unit order: package first
package ptm_pkg;

  // which register an address lands on
  typedef enum logic [2:0] {
    PTM_SEL_NONE,
    PTM_SEL_EN_MIRROR,
    PTM_SEL_ARM_MIRROR,
    PTM_SEL_LVL_MIRROR,
    PTM_SEL_TMR_LOW,
    PTM_SEL_TMR_HIGH,
    PTM_SEL_CTRL,
    PTM_SEL_LDCTRL
  } ptm_sel_t;

  typedef logic [7:0] ptm_byte_t;

endpackage

// File: core/ptm_cnt_bank.sv
// one generator's 16-bit timer counter storage, two software bytes plus a hardware load
// assumes all inputs come from logic on sys_clk; strobes are single-cycle
`include "ptm_defines.svh"

module ptm_cnt_bank (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire ptm_pkg::ptm_byte_t wr_data,
  input wire logic hw_load,
  input wire logic [15:0] hw_value,
  output logic [15:0] count
);

  logic [15:0] count_reg;
  logic [15:0] count_next;

  ////////////////////////////////////////////////////////////////////////////////
  // next value: software byte write beats the counting logic's load
  always_comb begin
    count_next = count_reg;
    if (hw_load) begin
      count_next = hw_value;
    end
    if (wr_low) begin
      count_next[7:0] = wr_data;
    end
    if (wr_high) begin
      count_next[15:8] = wr_data;
    end
  end

  // every reset clears both bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {`PTM_TMR_RST, `PTM_TMR_RST};
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_low_byte_write: assert property (clk_en && wr_low |=> count[7:0] == $past(wr_data))
    else $error("timer low byte did not take the written value");
  chk_high_byte_write: assert property (clk_en && wr_high |=> count[15:8] == $past(wr_data))
    else $error("timer high byte did not take the written value");
  chk_count_frozen: assert property (!clk_en |=> count == $past(count))
    else $error("timer count moved while clock enable was low");

endmodule

// File: core/ptm_mirror_bits.sv
// three storage bits reachable both as a shared mirror byte and one by one
// assumes mirror write and single-bit writes never come in the same cycle
`include "ptm_defines.svh"

module ptm_mirror_bits (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic grp_wr,
  input wire logic [`PTM_MIRROR_W-1:0] grp_data,
  input wire logic [`PTM_MIRROR_W-1:0] one_wr,
  input wire logic [`PTM_MIRROR_W-1:0] one_data,
  output logic [`PTM_MIRROR_W-1:0] bits
);

  logic [`PTM_MIRROR_W-1:0] bits_reg;
  logic [`PTM_MIRROR_W-1:0] bits_next;

  ////////////////////////////////////////////////////////////////////////////////
  // one store, two views
  always_comb begin
    bits_next = bits_reg;
    for (int i = 0; i < `PTM_MIRROR_W; i++) begin
      if (grp_wr) begin
        bits_next[i] = grp_data[i];
      end else if (one_wr[i]) begin
        bits_next[i] = one_data[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_reg <= `PTM_MIRROR_RST;
    end else if (clk_en) begin
      bits_reg <= bits_next;
    end
  end

  assign bits = bits_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_group_write: assert property (clk_en && grp_wr |=> bits == $past(grp_data))
    else $error("mirror write did not update all three bits together");
  chk_single_write: assert property (clk_en && !grp_wr && one_wr[0] |=> bits[0] == $past(one_data[0]))
    else $error("instance register write did not reach the shared bit");

endmodule

// File: core/ptm_top.sv
// register bank: timer count bytes of three pwm generators plus three shared mirror bytes
// assumes a plain same-clock register port; read data valid only in the cycle after rd_en
`include "ptm_defines.svh"

module ptm_top #(
  parameter int NUM_GEN = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [`PTM_ADDR_W-1:0] addr,
  input wire ptm_pkg::ptm_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [NUM_GEN-1:0] tmr_load,
  input wire logic [16*NUM_GEN-1:0] tmr_load_val,
  output ptm_pkg::ptm_byte_t rd_data,
  output logic [NUM_GEN-1:0] gen_on,
  output logic [NUM_GEN-1:0] gen_arm,
  output logic [NUM_GEN-1:0] gen_level,
  output logic [16*NUM_GEN-1:0] tmr_count
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check: the mirror bytes have exactly three slots
  if (NUM_GEN != `PTM_MIRROR_W) begin : g_bad_num_gen
    $error("ptm_top: NUM_GEN must be 3");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths
  function automatic ptm_pkg::ptm_sel_t dec_sel(input logic [`PTM_ADDR_W-1:0] a);
    ptm_pkg::ptm_sel_t s;
    s = ptm_pkg::PTM_SEL_NONE;
    if (a == `PTM_OFS_EN_MIRROR) begin
      s = ptm_pkg::PTM_SEL_EN_MIRROR;
    end else if (a == `PTM_OFS_ARM_MIRROR) begin
      s = ptm_pkg::PTM_SEL_ARM_MIRROR;
    end else if (a == `PTM_OFS_LVL_MIRROR) begin
      s = ptm_pkg::PTM_SEL_LVL_MIRROR;
    end else if (a[7:4] == `PTM_PAGE_GEN5 || a[7:4] == `PTM_PAGE_GEN6 ||
                 a[7:4] == `PTM_PAGE_GEN11) begin
      unique case (a[3:0])
        `PTM_SUB_TMR_LOW: s = ptm_pkg::PTM_SEL_TMR_LOW;
        `PTM_SUB_TMR_HIGH: s = ptm_pkg::PTM_SEL_TMR_HIGH;
        `PTM_SUB_CTRL: s = ptm_pkg::PTM_SEL_CTRL;
        `PTM_SUB_LDCTRL: s = ptm_pkg::PTM_SEL_LDCTRL;
        default: s = ptm_pkg::PTM_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // one-hot generator slot: bit 0 gen5, bit 1 gen6, bit 2 gen11
  function automatic logic [2:0] dec_gen(input logic [`PTM_ADDR_W-1:0] a);
    logic [2:0] g;
    g = 3'h0;
    g[0] = (a[7:4] == `PTM_PAGE_GEN5);
    g[1] = (a[7:4] == `PTM_PAGE_GEN6);
    g[2] = (a[7:4] == `PTM_PAGE_GEN11);
    return g;
  endfunction

  ptm_pkg::ptm_sel_t sel;
  logic [2:0] gen_hit;

  // decode once per cycle; strobes qualify it below
  always_comb begin
    sel = dec_sel(addr);
    gen_hit = dec_gen(addr);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write strobes per target
  logic [NUM_GEN-1:0] wr_tmr_low;
  logic [NUM_GEN-1:0] wr_tmr_high;
  logic [NUM_GEN-1:0] wr_ctrl;
  logic [NUM_GEN-1:0] wr_ldctrl;
  logic wr_en_mirror;
  logic wr_arm_mirror;
  logic wr_lvl_mirror;

  always_comb begin
    wr_tmr_low = wr_en && sel == ptm_pkg::PTM_SEL_TMR_LOW ? gen_hit : 3'h0;
    wr_tmr_high = wr_en && sel == ptm_pkg::PTM_SEL_TMR_HIGH ? gen_hit : 3'h0;
    wr_ctrl = wr_en && sel == ptm_pkg::PTM_SEL_CTRL ? gen_hit : 3'h0;
    wr_ldctrl = wr_en && sel == ptm_pkg::PTM_SEL_LDCTRL ? gen_hit : 3'h0;
    wr_en_mirror = wr_en && sel == ptm_pkg::PTM_SEL_EN_MIRROR;
    wr_arm_mirror = wr_en && sel == ptm_pkg::PTM_SEL_ARM_MIRROR;
    wr_lvl_mirror = wr_en && sel == ptm_pkg::PTM_SEL_LVL_MIRROR;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer counter storage, one bank per generator
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_cnt
    ptm_cnt_bank u_cnt (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wr_low(wr_tmr_low[g]),
      .wr_high(wr_tmr_high[g]),
      .wr_data(wr_data),
      .hw_load(tmr_load[g]),
      .hw_value(tmr_load_val[16*g +: 16]),
      .count(tmr_count[16*g +: 16])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared bits: instance registers and mirror bytes write the same flops,
  // so no copy can ever disagree with its source
  // enable store
  ptm_mirror_bits u_on (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .grp_wr(wr_en_mirror),
    .grp_data(wr_data[`PTM_MIRROR_W-1:0]),
    .one_wr(wr_ctrl),
    .one_data({NUM_GEN{wr_data[`PTM_CTRL_ON_BIT]}}),
    .bits(gen_on)
  );

  ptm_mirror_bits u_arm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .grp_wr(wr_arm_mirror),
    .grp_data(wr_data[`PTM_MIRROR_W-1:0]),
    .one_wr(wr_ldctrl),
    .one_data({NUM_GEN{wr_data[`PTM_LDCTRL_ARM_BIT]}}),
    .bits(gen_arm)
  );

  ptm_mirror_bits u_level (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .grp_wr(wr_lvl_mirror),
    .grp_data(wr_data[`PTM_MIRROR_W-1:0]),
    .one_wr(wr_ctrl),
    .one_data({NUM_GEN{wr_data[`PTM_CTRL_LEVEL_BIT]}}),
    .bits(gen_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read path: data stand in the cycle after an enabled strobe, zero after other enabled cycles, held while clk_en is low
  ptm_pkg::ptm_byte_t rd_data_reg;
  ptm_pkg::ptm_byte_t rd_data_next;
  logic [1:0] gidx;

  always_comb begin
    gidx = 2'd0;
    if (gen_hit[1]) begin
      gidx = 2'd1;
    end else if (gen_hit[2]) begin
      gidx = 2'd2;
    end
    rd_data_next = `PTM_RDATA_RST;
    if (rd_en) begin
      unique case (sel)
        ptm_pkg::PTM_SEL_EN_MIRROR: rd_data_next = {5'h00, gen_on};
        ptm_pkg::PTM_SEL_ARM_MIRROR: rd_data_next = {5'h00, gen_arm};
        ptm_pkg::PTM_SEL_LVL_MIRROR: rd_data_next = {5'h00, gen_level};
        ptm_pkg::PTM_SEL_TMR_LOW: rd_data_next = tmr_count[16*gidx +: 8];
        ptm_pkg::PTM_SEL_TMR_HIGH: rd_data_next = tmr_count[16*gidx + 8 +: 8];
        ptm_pkg::PTM_SEL_CTRL: begin
          rd_data_next[`PTM_CTRL_ON_BIT] = gen_on[gidx];
          rd_data_next[`PTM_CTRL_LEVEL_BIT] = gen_level[gidx];
        end
        ptm_pkg::PTM_SEL_LDCTRL: rd_data_next[`PTM_LDCTRL_ARM_BIT] = gen_arm[gidx];
        ptm_pkg::PTM_SEL_NONE: rd_data_next = `PTM_RDATA_RST; // unmapped reads zero
      endcase
    end
  end

  // register the answer so the port comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= `PTM_RDATA_RST;
    end else if (clk_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the register view
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd(ptm_pkg::ptm_sel_t s);
    clk_en && rd_en && sel == s;
  endsequence

  chk_en_mirror_read: assert property (s_rd(ptm_pkg::PTM_SEL_EN_MIRROR) |=>
      rd_data[2:0] == $past(gen_on))
    else $error("enable mirror read does not show the enable bits");
  chk_arm_mirror_read: assert property (s_rd(ptm_pkg::PTM_SEL_ARM_MIRROR) |=>
      rd_data[2:0] == $past(gen_arm))
    else $error("load-arm mirror read does not show the arm bits");
  chk_lvl_mirror_read: assert property (s_rd(ptm_pkg::PTM_SEL_LVL_MIRROR) |=>
      rd_data[2:0] == $past(gen_level))
    else $error("output mirror read does not show the output bits");
  chk_mirror_upper_zero: assert property (clk_en && rd_en && addr[7:2] == 6'h00 |=>
      rd_data[7:3] == 5'h00)
    else $error("mirror upper bits read nonzero");
  chk_mirror_ignore_upper: assert property (clk_en && wr_en_mirror ##1 clk_en && rd_en &&
      sel == ptm_pkg::PTM_SEL_EN_MIRROR |=> rd_data == (8'($past(wr_data, 2)) & 8'h07))
    else $error("mirror write leaked into upper bits");
  chk_tmr_low_read: assert property (clk_en && wr_tmr_low[0] && !tmr_load[0] ##1
      clk_en && rd_en && sel == ptm_pkg::PTM_SEL_TMR_LOW && gen_hit[0] |=>
      rd_data == $past(wr_data, 2))
    else $error("timer low byte read back differs from write");
  chk_ctrl_hits_mirror: assert property (clk_en && wr_ctrl[2] |=>
      gen_on[2] == $past(wr_data[7]) && gen_level[2] == $past(wr_data[5]))
    else $error("control write did not change the shared bits");
  chk_rd_only_once: assert property (clk_en && !rd_en |=> rd_data == 8'h00)
    else $error("read data stood outside the answer cycle");
  chk_reset_clear: assert property ($rose(rst_n) |->
      tmr_count == '0 && gen_on == 3'h0 && gen_arm == 3'h0 && gen_level == 3'h0)
    else $error("state not cleared by reset");

  cov_group_enable: cover property (clk_en && wr_en_mirror && wr_data[2:0] == 3'h7);
  cov_arm_read: cover property (s_rd(ptm_pkg::PTM_SEL_LDCTRL) ##1 rd_data[7]);
  cov_tmr_high_read: cover property (s_rd(ptm_pkg::PTM_SEL_TMR_HIGH) ##1 rd_data != 8'h00);
  cov_back_to_back: cover property (clk_en && wr_ctrl[1] ##1 s_rd(ptm_pkg::PTM_SEL_EN_MIRROR));

endmodule

// File: test/ptm_tb.sv
// self-checking bench for the pwm timer/mirror register bank
// assumes ptm_top with NUM_GEN=3 and the address map of ptm_defines.svh
`include "ptm_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observation signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  ptm_pkg::ptm_byte_t wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [2:0] tmr_load = 3'h0;
  logic [47:0] tmr_load_val = 48'h0000_0000_0000;
  ptm_pkg::ptm_byte_t rd_data;
  logic [2:0] gen_on;
  logic [2:0] gen_arm;
  logic [2:0] gen_level;
  logic [47:0] tmr_count;
  int failures = 0;
  int check_count = 0;

  ptm_top #(.NUM_GEN(3)) DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .tmr_load(tmr_load),
    .tmr_load_val(tmr_load_val),
    .rd_data(rd_data),
    .gen_on(gen_on),
    .gen_arm(gen_arm),
    .gen_level(gen_level),
    .tmr_count(tmr_count)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks, one per result width
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp3(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bus cycles: one-cycle strobe, effect settled just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    cmp8(name, exp, rd_data);
  endtask

  // address of a register inside one generator page
  function automatic logic [7:0] ga(input int g, input logic [3:0] sub);
    logic [3:0] p;
    p = (g == 0) ? `PTM_PAGE_GEN5 : (g == 1) ? `PTM_PAGE_GEN6 : `PTM_PAGE_GEN11;
    return {p, sub};
  endfunction

  // all state must read zero after any reset
  task automatic check_cleared();
    cmp3("gen_on", 3'h0, gen_on);
    cmp3("gen_arm", 3'h0, gen_arm);
    cmp3("gen_level", 3'h0, gen_level);
    for (int g = 0; g < 3; g++) begin
      cmp16("tmr_count", 16'h0000, tmr_count[16*g +: 16]);
      rd(ga(g, `PTM_SUB_TMR_LOW), 8'h00, "timer_count_low");
      rd(ga(g, `PTM_SUB_TMR_HIGH), 8'h00, "timer_count_high");
    end
    rd(`PTM_OFS_EN_MIRROR, 8'h00, "shared_enable_mirror");
    rd(`PTM_OFS_ARM_MIRROR, 8'h00, "shared_load_arm_mirror");
    rd(`PTM_OFS_LVL_MIRROR, 8'h00, "shared_output_mirror");
  endtask

  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check_cleared();
    // distinct bytes per generator, boundary 0xff in the first
    for (int g = 0; g < 3; g++) begin
      wr(ga(g, `PTM_SUB_TMR_LOW), 8'hff - 8'(g));
      wr(ga(g, `PTM_SUB_TMR_HIGH), 8'h80 + 8'(g));
    end
    for (int g = 0; g < 3; g++) begin
      cmp16("tmr_count", {8'h80 + 8'(g), 8'hff - 8'(g)}, tmr_count[16*g +: 16]);
      rd(ga(g, `PTM_SUB_TMR_LOW), 8'hff - 8'(g), "timer_count_low");
      rd(ga(g, `PTM_SUB_TMR_HIGH), 8'h80 + 8'(g), "timer_count_high");
    end
    // read answer stands for one cycle only
    @(posedge sys_clk);
    #1;
    cmp8("rd_data idle", 8'h00, rd_data);
    // one mirror write turns all three on at once; upper bits dropped
    wr(`PTM_OFS_EN_MIRROR, 8'hff);
    cmp3("gen_on", 3'h7, gen_on);
    rd(`PTM_OFS_EN_MIRROR, 8'h07, "shared_enable_mirror");
    wr(`PTM_OFS_EN_MIRROR, 8'h05);
    cmp3("gen_on", 3'h5, gen_on);
    rd(ga(0, `PTM_SUB_CTRL), 8'h80, "instance_control gen5");
    rd(ga(1, `PTM_SUB_CTRL), 8'h00, "instance_control gen6");
    // instance write shows in both mirrors
    wr(ga(1, `PTM_SUB_CTRL), 8'ha0);
    cmp3("gen_on", 3'h7, gen_on);
    cmp3("gen_level", 3'h2, gen_level);
    rd(`PTM_OFS_LVL_MIRROR, 8'h02, "shared_output_mirror");
    rd(`PTM_OFS_EN_MIRROR, 8'h07, "shared_enable_mirror");
    // load-arm mirror and instance load control
    wr(`PTM_OFS_ARM_MIRROR, 8'hfa);
    cmp3("gen_arm", 3'h2, gen_arm);
    rd(`PTM_OFS_ARM_MIRROR, 8'h02, "shared_load_arm_mirror");
    rd(ga(1, `PTM_SUB_LDCTRL), 8'h80, "instance_load_control gen6");
    wr(ga(2, `PTM_SUB_LDCTRL), 8'h80);
    cmp3("gen_arm", 3'h6, gen_arm);
    rd(`PTM_OFS_ARM_MIRROR, 8'h06, "shared_load_arm_mirror");
    // output mirror write reaches the instance control byte
    wr(`PTM_OFS_LVL_MIRROR, 8'hfc);
    cmp3("gen_level", 3'h4, gen_level);
    rd(ga(2, `PTM_SUB_CTRL), 8'ha0, "instance_control gen11");
    rd(ga(1, `PTM_SUB_CTRL), 8'h80, "instance_control gen6");
    // unmapped place ignores writes and reads zero
    wr(8'h7f, 8'hff);
    rd(8'h7f, 8'h00, "unmapped");
    cmp3("gen_on", 3'h7, gen_on);
    // frozen clock enable drops a write
    clk_en <= 1'b0;
    wr(ga(0, `PTM_SUB_TMR_LOW), 8'h12);
    clk_en <= 1'b1;
    rd(ga(0, `PTM_SUB_TMR_LOW), 8'hff, "timer_count_low frozen");
    // hardware load of gen11, seen through the low and high bytes
    @(posedge sys_clk);
    tmr_load <= 3'h4;
    tmr_load_val <= 48'hbeef_0000_0000;
    @(posedge sys_clk);
    tmr_load <= 3'h0;
    #1;
    cmp16("tmr_count gen11", 16'hbeef, tmr_count[47:32]);
    rd(ga(2, `PTM_SUB_TMR_LOW), 8'hef, "timer_count_low gen11");
    rd(ga(2, `PTM_SUB_TMR_HIGH), 8'hbe, "timer_count_high gen11");
    // second reset in mid-run clears everything
    @(posedge sys_clk);
    rst_n <= 1'b0;
    #1;
    cmp3("gen_on in reset", 3'h0, gen_on);
    cmp16("tmr_count in reset", 16'h0000, tmr_count[47:32]);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check_cleared();
    stop_test();
  end
endmodule
